//--- core/wit_defines.svh
`ifndef WIT_DEFINES_SVH
`define WIT_DEFINES_SVH

// ==========================================
// addresses
`define WIT_ADDR_CSR 32'hffff8610
`define WIT_ADDR_CNT 32'hffff8611
`define WIT_ADDR_RCSR_W 32'hffff8612
`define WIT_ADDR_RCSR_R 32'hffff8613
`define WIT_ADDR_IRQ_STS 32'hffff8614
`define WIT_ADDR_IRQ_MSK 32'hffff8615

// ==========================================
// access sizes and keys
`define WIT_SZ_BYTE 2'h0
`define WIT_SZ_WORD 2'h1
`define WIT_KEY_A 8'ha5
`define WIT_KEY_B 8'h5a

// ==========================================
// fields and reset values
`define WIT_CSR_RESET 8'h18
`define WIT_CSR_RSV 8'h18
`define WIT_CSR_OVF 7
`define WIT_CSR_WTIT 6
`define WIT_CSR_TME 5
`define WIT_CSR_CKS 2:0
`define WIT_RCSR_RESET 8'h1f
`define WIT_RCSR_RSV 8'h1f
`define WIT_RCSR_WOVF 7
`define WIT_RCSR_RSTE 6
`define WIT_RCSR_RSTS 5
`define WIT_CNT_RESET 8'h00
`define WIT_CNT_MAX 8'hff
`define WIT_CNT_ONE 8'h01
`define WIT_IRQ_RESET 8'h00
`define WIT_IRQ_ITV 0
`define WIT_IRQ_WDT 1
`define WIT_IRQ_MANUAL_RESET_PIN 2

// ==========================================
// timing
`define WIT_CLK_NS 4
`define WIT_OVF_PULSE_NS 512
`define WIT_RST_PULSE_NS 2048
`define WIT_OVF_PULSE_CYC ((`WIT_OVF_PULSE_NS + `WIT_CLK_NS - 1) / `WIT_CLK_NS)
`define WIT_RST_PULSE_CYC ((`WIT_RST_PULSE_NS + `WIT_CLK_NS - 1) / `WIT_CLK_NS)
`define WIT_DIV_EXPS '{1, 6, 7, 8, 9, 10, 12, 13}
`define WIT_DIV_W 13

`endif

//--- core/wit_pkg.sv
package wit_pkg;
  typedef enum logic [1:0] {
    WIT_RUN = 2'h0,
    WIT_STBY = 2'h1,
    WIT_WAKE = 2'h2
  } wit_state_e;
  typedef logic [7:0] wit_byte_t;
  typedef logic [9:0] wit_pulse_t;
endpackage

//--- core/wit_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wit_tick_if;
  logic clr;
  logic [2:0] sel;
  logic tick;
  modport ctrl (output clr, output sel, input tick);
  modport pre (input clr, input sel, output tick);
endinterface
`default_nettype wire

//--- core/wit_sync.sv
`timescale 1ns/10ps
`default_nettype none
module wit_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // async level in, synced out
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

//--- core/wit_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "wit_defines.svh"
module wit_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // tick link
  wit_tick_if.pre tk
);
  localparam int EXPS [8] = `WIT_DIV_EXPS;
  logic [`WIT_DIV_W-1:0] div_q;
  logic [7:0] hit;
  logic tick_q;

  // ==========================================
  // free divider, cleared while idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (tk.clr) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + `WIT_DIV_W'(1);
    end
  end

  // ==========================================
  // one tap per prescale choice
  for (genvar g = 0; g < 8; g++) begin : g_tap
    assign hit[g] = &div_q[EXPS[g]-1:0];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= hit[tk.sel] & ~tk.clr;
    end
  end

  assign tk.tick = tick_q;
endmodule
`default_nettype wire

//--- core/wit_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "wit_defines.svh"
module wit_top
  import wit_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [1:0] size,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // system pins and events
  input wire logic manual_reset_pin_n,
  input wire logic standby,
  input wire logic nmi_wake,
  // outputs
  output logic watchdog_overflow_output_n,
  output logic interval_interrupt,
  output logic internal_reset_req,
  output logic internal_reset_manual,
  output logic clock_stable,
  output logic irq
);
  // ==========================================
  // declarations
  wit_tick_if tk ();
  wit_state_e state_q, state_d;
  wit_byte_t cnt_q, cnt_d;
  wit_byte_t csr_q, csr_d;
  wit_byte_t rcsr_q, rcsr_d;
  wit_byte_t sts_q, sts_d;
  wit_byte_t msk_q, msk_d;
  wit_byte_t rdata_q, rsel;
  wit_pulse_t opulse_q, opulse_d;
  wit_pulse_t rpulse_q, rpulse_d;
  logic wovf_n_q, itv_q, rreq_q, rman_q, stable_q, irq_q;
  logic manual_reset_pin_s, manual_reset_pin_d1_q;
  logic wr_word, rd_byte;
  logic [7:0] key, val;
  logic w_csr, w_cnt, w_rctl, w_rclr, w_msk, r_sts;
  logic running, rst_hold, ovf, ovf_run;
  logic wdt_evt, itv_evt, wake_done, manual_reset_pin_fall;

  // ==========================================
  // submodules
  wit_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .din(manual_reset_pin_n),
    .dout(manual_reset_pin_s)
  );

  wit_prescaler u_pre (
    .clk(clk),
    .resetn(resetn),
    .tk(tk)
  );

  // ==========================================
  // access decode
  // word writes only
  assign wr_word = wr & (size == `WIT_SZ_WORD);
  assign rd_byte = rd & (size == `WIT_SZ_BYTE);
  assign key = wdata[15:8];
  assign val = wdata[7:0];
  assign w_csr = wr_word & (addr == `WIT_ADDR_CSR) & (key == `WIT_KEY_A);
  assign w_cnt = wr_word & (addr == `WIT_ADDR_CSR) & (key == `WIT_KEY_B);
  assign w_rctl = wr_word & (addr == `WIT_ADDR_RCSR_W) & (key == `WIT_KEY_A);
  assign w_rclr = wr_word & (addr == `WIT_ADDR_RCSR_W) & (key == `WIT_KEY_B) & ~val[`WIT_RCSR_WOVF];
  assign w_msk = wr_word & (addr == `WIT_ADDR_IRQ_STS) & (key == `WIT_KEY_A);
  assign r_sts = rd_byte & (addr == `WIT_ADDR_IRQ_STS);

  // ==========================================
  // counting conditions
  // count enable and prescale
  assign running = ((state_q == WIT_RUN) & csr_q[`WIT_CSR_TME]) | (state_q == WIT_WAKE);
  assign rst_hold = (rpulse_q != '0);
  assign tk.clr = ~running | rst_hold;
  assign tk.sel = csr_q[`WIT_CSR_CKS];
  assign ovf = tk.tick & running & ~rst_hold & ~w_cnt & (cnt_q == `WIT_CNT_MAX);
  assign ovf_run = ovf & (state_q == WIT_RUN);
  assign wdt_evt = ovf_run & csr_q[`WIT_CSR_WTIT];
  assign itv_evt = ovf_run & ~csr_q[`WIT_CSR_WTIT];
  assign wake_done = ovf & (state_q == WIT_WAKE);
  assign manual_reset_pin_fall = manual_reset_pin_d1_q & ~manual_reset_pin_s;

  // ==========================================
  // standby state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      WIT_RUN: begin
        if (standby) begin
          state_d = WIT_STBY;
        end
      end
      WIT_STBY: begin
        if (nmi_wake) begin
          state_d = WIT_WAKE;
        end else if (manual_reset_pin_fall) begin
          state_d = WIT_RUN;
        end
      end
      WIT_WAKE: begin
        if (wake_done) begin
          state_d = WIT_RUN;
        end
      end
      default: begin
        state_d = WIT_RUN;
      end
    endcase
  end

  // ==========================================
  // counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (rst_hold) begin
      cnt_d = `WIT_CNT_RESET;
    end else if (w_csr & ~val[`WIT_CSR_TME]) begin
      cnt_d = `WIT_CNT_RESET;
    end else if (w_cnt) begin
      cnt_d = val;
    end else if (tk.tick & running) begin
      cnt_d = cnt_q + `WIT_CNT_ONE;
    end
  end

  // ==========================================
  // control registers
  always_comb begin
    csr_d = csr_q;
    if (w_csr) begin
      csr_d = val | `WIT_CSR_RSV;
      csr_d[`WIT_CSR_OVF] = csr_q[`WIT_CSR_OVF] & val[`WIT_CSR_OVF];
    end
    if (ovf_run) begin
      csr_d[`WIT_CSR_OVF] = 1'b1;
    end
  end

  always_comb begin
    rcsr_d = rcsr_q;
    if (w_rctl) begin
      rcsr_d = val | `WIT_RCSR_RSV;
      rcsr_d[`WIT_RCSR_WOVF] = rcsr_q[`WIT_RCSR_WOVF];
    end
    if (w_rclr) begin
      rcsr_d[`WIT_RCSR_WOVF] = 1'b0;
    end
    if (wdt_evt) begin
      rcsr_d[`WIT_RCSR_WOVF] = 1'b1;
    end
  end

  // ==========================================
  // interrupt status and mask
  always_comb begin
    sts_d = r_sts ? `WIT_IRQ_RESET : sts_q;
    sts_d[`WIT_IRQ_ITV] = sts_d[`WIT_IRQ_ITV] | itv_evt;
    sts_d[`WIT_IRQ_WDT] = sts_d[`WIT_IRQ_WDT] | wdt_evt;
    sts_d[`WIT_IRQ_MANUAL_RESET_PIN] = sts_d[`WIT_IRQ_MANUAL_RESET_PIN] | manual_reset_pin_fall;
  end

  assign msk_d = w_msk ? val : msk_q;

  // ==========================================
  // pulse timers
  // watchdog overflow pulse
  assign opulse_d = wdt_evt ? wit_pulse_t'(`WIT_OVF_PULSE_CYC) :
                    (opulse_q != '0) ? opulse_q - wit_pulse_t'(1) : opulse_q;
  assign rpulse_d = (wdt_evt & rcsr_q[`WIT_RCSR_RSTE]) ? wit_pulse_t'(`WIT_RST_PULSE_CYC) :
                    (rpulse_q != '0) ? rpulse_q - wit_pulse_t'(1) : rpulse_q;

  // ==========================================
  // read mux
  always_comb begin
    rsel = `WIT_IRQ_RESET;
    if (addr == `WIT_ADDR_CSR) begin
      rsel = csr_q;
    end else if (addr == `WIT_ADDR_CNT) begin
      rsel = cnt_q;
    end else if (addr == `WIT_ADDR_RCSR_R) begin
      rsel = rcsr_q;
    end else if (addr == `WIT_ADDR_IRQ_STS) begin
      rsel = sts_q;
    end else if (addr == `WIT_ADDR_IRQ_MSK) begin
      rsel = msk_q;
    end
  end

  // ==========================================
  // state flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= WIT_RUN;
      cnt_q <= `WIT_CNT_RESET;
      csr_q <= `WIT_CSR_RESET;
      rcsr_q <= `WIT_RCSR_RESET;
      sts_q <= `WIT_IRQ_RESET;
      msk_q <= `WIT_IRQ_RESET;
      opulse_q <= '0;
      rpulse_q <= '0;
      manual_reset_pin_d1_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      csr_q <= csr_d;
      rcsr_q <= rcsr_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      opulse_q <= opulse_d;
      rpulse_q <= rpulse_d;
      manual_reset_pin_d1_q <= manual_reset_pin_s;
    end
  end

  // ==========================================
  // output flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= `WIT_IRQ_RESET;
      wovf_n_q <= 1'b1;
      itv_q <= 1'b0;
      rreq_q <= 1'b0;
      rman_q <= 1'b0;
      stable_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rd_byte ? rsel : `WIT_IRQ_RESET;
      wovf_n_q <= (opulse_d == '0);
      itv_q <= csr_d[`WIT_CSR_OVF] & ~csr_d[`WIT_CSR_WTIT];
      rreq_q <= (rpulse_d != '0);
      rman_q <= (rpulse_d != '0) & rcsr_q[`WIT_RCSR_RSTS];
      stable_q <= wake_done;
      irq_q <= |(sts_d & msk_d);
    end
  end

  assign rdata = rdata_q;
  assign watchdog_overflow_output_n = wovf_n_q;
  assign interval_interrupt = itv_q;
  assign internal_reset_req = rreq_q;
  assign internal_reset_manual = rman_q;
  assign clock_stable = stable_q;
  assign irq = irq_q;

  // ==========================================
  // checks
  chk_count_read_back: assert property (@(posedge clk) disable iff (!resetn)
    rd_byte && addr == `WIT_ADDR_CNT |=> rdata == $past(cnt_q))
    else $error("counter read data wrong");

  chk_count_step_one: assert property (@(posedge clk) disable iff (!resetn)
    tk.tick && running && !rst_hold && !w_cnt && !w_csr |=> cnt_q == $past(cnt_q) + `WIT_CNT_ONE)
    else $error("counter did not step");

  chk_wdt_pulse_low: assert property (@(posedge clk) disable iff (!resetn)
    wdt_evt |=> !watchdog_overflow_output_n [*8])
    else $error("overflow output not held low");

  chk_itv_raise: assert property (@(posedge clk) disable iff (!resetn)
    itv_evt |=> interval_interrupt && watchdog_overflow_output_n == $past(watchdog_overflow_output_n))
    else $error("interval interrupt missing");

  chk_tme_zeroes: assert property (@(posedge clk) disable iff (!resetn)
    w_csr && !wdata[`WIT_CSR_TME] |=> cnt_q == `WIT_CNT_RESET && !csr_q[`WIT_CSR_TME])
    else $error("counter not cleared by disable");

  chk_stby_holds: assert property (@(posedge clk) disable iff (!resetn)
    state_q == WIT_STBY && !w_cnt && !w_csr && !rst_hold |=> cnt_q == $past(cnt_q))
    else $error("counter moved in standby");

  chk_rst_clears: assert property (@(posedge clk) disable iff (!resetn)
    wdt_evt && rcsr_q[`WIT_RCSR_RSTE] |=> internal_reset_req ##1 cnt_q == `WIT_CNT_RESET)
    else $error("watchdog reset did not clear counter");

  chk_word_write: assert property (@(posedge clk) disable iff (!resetn)
    wr && size != `WIT_SZ_WORD |=> csr_q[6:0] == $past(csr_q[6:0]) && rcsr_q[6:0] == $past(rcsr_q[6:0]))
    else $error("non-word write changed control");

  chk_byte_read: assert property (@(posedge clk) disable iff (!resetn)
    rd && size != `WIT_SZ_BYTE |=> rdata == `WIT_IRQ_RESET)
    else $error("non-byte read returned data");

  chk_flag_no_set: assert property (@(posedge clk) disable iff (!resetn)
    !csr_q[`WIT_CSR_OVF] && !ovf_run |=> !csr_q[`WIT_CSR_OVF])
    else $error("flag set without wrap");

  chk_bad_key: assert property (@(posedge clk) disable iff (!resetn)
    wr_word && addr == `WIT_ADDR_CSR && key != `WIT_KEY_A && key != `WIT_KEY_B
    |=> csr_q[6:0] == $past(csr_q[6:0]))
    else $error("unkeyed write took effect");

  chk_wake_done: assert property (@(posedge clk) disable iff (!resetn)
    wake_done |=> clock_stable && state_q == WIT_RUN)
    else $error("wake overflow not signalled");

  chk_wrap_flag: assert property (@(posedge clk) disable iff (!resetn)
    ovf_run |=> csr_q[`WIT_CSR_OVF] && cnt_q == `WIT_CNT_RESET)
    else $error("wrap flag not set");
endmodule
`default_nettype wire

//--- dv/tb_watchdog_interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "wit_defines.svh"
module tb_watchdog_interval_timer
  import wit_pkg::*;
;
  // ==========================================
  // signals
  logic clk;
  logic resetn;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [1:0] size;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic manual_reset_pin_n;
  logic standby;
  logic nmi_wake;
  logic watchdog_overflow_output_n;
  logic interval_interrupt;
  logic internal_reset_req;
  logic internal_reset_manual;
  logic clock_stable;
  logic irq;
  int num_errors;
  int compares;
  logic [7:0] held;
  wire logic [4:0] obs;

  // observed outputs: interval, overflow, reset, stable, irq
  assign obs = {irq, clock_stable, internal_reset_req, ~watchdog_overflow_output_n, interval_interrupt};

  wit_top dut (
    .clk(clk),
    .resetn(resetn),
    .addr(addr),
    .wdata(wdata),
    .size(size),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .manual_reset_pin_n(manual_reset_pin_n),
    .standby(standby),
    .nmi_wake(nmi_wake),
    .watchdog_overflow_output_n(watchdog_overflow_output_n),
    .interval_interrupt(interval_interrupt),
    .internal_reset_req(internal_reset_req),
    .internal_reset_manual(internal_reset_manual),
    .clock_stable(clock_stable),
    .irq(irq)
  );

  // ==========================================
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================
  // tasks
  task final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr_reg(input logic [31:0] a, input logic [7:0] key, input logic [7:0] val, input logic [1:0] sz);
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0000, key, val};
    size <= sz;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_get(input logic [31:0] a, input logic [1:0] sz, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    size <= sz;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task rd_chk(input string name, input logic [31:0] a, input logic [1:0] sz, input logic [7:0] exp);
    logic [7:0] d;
    rd_get(a, sz, d);
    chk(name, exp, d);
  endtask

  task wait_obs(input int idx, input logic lvl, input int lim);
    int n;
    n = 0;
    while (obs[idx] !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    compares++;
    if (obs[idx] !== lvl) begin
      num_errors++;
      $display("Error output %0d expected %b seen %b", idx, lvl, obs[idx]);
      final_report();
    end
  endtask

  task pulse_in(input int which);
    @(posedge clk);
    if (which == 0) standby <= 1'b1;
    else if (which == 1) nmi_wake <= 1'b1;
    else manual_reset_pin_n <= 1'b0;
    @(posedge clk);
    standby <= 1'b0;
    nmi_wake <= 1'b0;
    repeat (10) @(posedge clk);
    manual_reset_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // ==========================================
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("Error run expected done seen timeout");
    final_report();
  end

  // ==========================================
  // main sequence
  initial begin
    resetn = 1'b0;
    addr = 32'h00000000;
    wdata = 32'h00000000;
    size = 2'h0;
    wr = 1'b0;
    rd = 1'b0;
    manual_reset_pin_n = 1'b1;
    standby = 1'b0;
    nmi_wake = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'h18);
    rd_chk("count", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'h00);
    rd_chk("rstctrl", `WIT_ADDR_RCSR_R, `WIT_SZ_BYTE, 8'h1f);
    rd_chk("status", `WIT_ADDR_IRQ_STS, `WIT_SZ_BYTE, 8'h00);
    rd_chk("mask", `WIT_ADDR_IRQ_MSK, `WIT_SZ_BYTE, 8'h00);
    rd_chk("unmapped", 32'hffff8616, `WIT_SZ_BYTE, 8'h00);
    // refused writes and reads
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'h27, `WIT_SZ_BYTE);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'h27, 2'h2);
    wr_reg(`WIT_ADDR_CSR, 8'h00, 8'h27, `WIT_SZ_WORD);
    wr_reg(`WIT_ADDR_CNT, `WIT_KEY_B, 8'h33, `WIT_SZ_WORD);
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'h18);
    rd_chk("count", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'h00);
    rd_chk("ctrl word", `WIT_ADDR_CSR, `WIT_SZ_WORD, 8'h00);
    // keyed counter write, interval wrap
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_B, 8'hfd, `WIT_SZ_WORD);
    rd_chk("count", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'hfd);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'h20, `WIT_SZ_WORD);
    wait_obs(0, 1'b1, 100);
    chk("irq masked", 8'h00, {7'h00, irq});
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'hb8);
    wr_reg(`WIT_ADDR_IRQ_STS, `WIT_KEY_A, 8'h01, `WIT_SZ_WORD);
    wait_obs(4, 1'b1, 4);
    rd_chk("mask", `WIT_ADDR_IRQ_MSK, `WIT_SZ_BYTE, 8'h01);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'ha0, `WIT_SZ_WORD);
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'hb8);
    rd_chk("status", `WIT_ADDR_IRQ_STS, `WIT_SZ_BYTE, 8'h01);
    wait_obs(4, 1'b0, 4);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'h20, `WIT_SZ_WORD);
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'h38);
    chk("interval", 8'h00, {7'h00, interval_interrupt});
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'ha0, `WIT_SZ_WORD);
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'h38);
    // standby hold, pin exit
    pulse_in(0);
    rd_get(`WIT_ADDR_CNT, `WIT_SZ_BYTE, held);
    repeat (20) @(posedge clk);
    rd_chk("count standby", `WIT_ADDR_CNT, `WIT_SZ_BYTE, held);
    pulse_in(2);
    rd_chk("status", `WIT_ADDR_IRQ_STS, `WIT_SZ_BYTE, 8'h04);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'h00, `WIT_SZ_WORD);
    rd_chk("count", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'h00);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_B, 8'h40, `WIT_SZ_WORD);
    pulse_in(2);
    rd_chk("count pin", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'h40);
    rd_chk("status", `WIT_ADDR_IRQ_STS, `WIT_SZ_BYTE, 8'h04);
    // watchdog wrap with internal reset
    wr_reg(`WIT_ADDR_RCSR_W, `WIT_KEY_A, 8'h60, `WIT_SZ_WORD);
    rd_chk("rstctrl", `WIT_ADDR_RCSR_R, `WIT_SZ_BYTE, 8'h7f);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_B, 8'hfe, `WIT_SZ_WORD);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'h60, `WIT_SZ_WORD);
    wait_obs(1, 1'b1, 100);
    chk("interval", 8'h00, {7'h00, interval_interrupt});
    wait_obs(2, 1'b1, 4);
    chk("reset manual", 8'h01, {7'h00, internal_reset_manual});
    rd_chk("count reset", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'h00);
    rd_chk("rstctrl", `WIT_ADDR_RCSR_R, `WIT_SZ_BYTE, 8'hff);
    rd_chk("status", `WIT_ADDR_IRQ_STS, `WIT_SZ_BYTE, 8'h02);
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'hf8);
    wait_obs(1, 1'b0, 200);
    wait_obs(2, 1'b0, 600);
    chk("reset manual", 8'h00, {7'h00, internal_reset_manual});
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_A, 8'h00, `WIT_SZ_WORD);
    wr_reg(`WIT_ADDR_RCSR_W, `WIT_KEY_B, 8'h80, `WIT_SZ_WORD);
    rd_chk("rstctrl", `WIT_ADDR_RCSR_R, `WIT_SZ_BYTE, 8'hff);
    wr_reg(`WIT_ADDR_RCSR_W, `WIT_KEY_B, 8'h00, `WIT_SZ_WORD);
    rd_chk("rstctrl", `WIT_ADDR_RCSR_R, `WIT_SZ_BYTE, 8'h7f);
    // wake from standby by nmi
    wr_reg(`WIT_ADDR_RCSR_W, `WIT_KEY_A, 8'h00, `WIT_SZ_WORD);
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_B, 8'hfe, `WIT_SZ_WORD);
    pulse_in(0);
    @(posedge clk);
    nmi_wake <= 1'b1;
    @(posedge clk);
    nmi_wake <= 1'b0;
    wait_obs(3, 1'b1, 100);
    rd_chk("ctrl", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'h18);
    rd_chk("status", `WIT_ADDR_IRQ_STS, `WIT_SZ_BYTE, 8'h00);
    // power-on reset in mid-run
    wr_reg(`WIT_ADDR_CSR, `WIT_KEY_B, 8'h40, `WIT_SZ_WORD);
    rd_chk("count", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'h40);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("count por", `WIT_ADDR_CNT, `WIT_SZ_BYTE, 8'h00);
    rd_chk("ctrl por", `WIT_ADDR_CSR, `WIT_SZ_BYTE, 8'h18);
    final_report();
  end
endmodule
`default_nettype wire
